// [include/dimap_pkg.sv]
// Constants, types and carriers for the digital input function mapper.
// Assumes a single 25 MHz system clock and a plain register port.
//
// Contract
// - Eight inputs, each mapped by its own parameter
// - Servo-on code 01h enables power stage
// - Servo-on ignored while any error present
// - Code 02h resets faults; cause removed first
// - Code 03h raises gain per gain parameter
// - Code 04h clears deviation per clear parameter
// - Deviation clear only in linear control 4001h
// - Code 05h stops slow motor in velocity
// - Zero clamp behaviour from extended bit 10
// - Torque modes coast on power stage disable
// - Code 2Ch picks low or high pulses
// - Code 46h stops motor, sequence mode only
// - Code 42h runs sequence from first set
// - Servo-on or fault-reset rise clears error
// - Exclusive access keeps safety inputs, drops pulses
package dimap_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int NUM_INPUTS = 8;        // Digital inputs
   localparam int ADDR_W     = 5;        // Register address width
   localparam int DATA_W     = 16;       // Register data width
   localparam int CODE_W     = 8;        // Function code width
   localparam int MODE_W     = 4;        // Operating mode code width
   localparam int NUM_FUNCS  = 13;       // Decoded functions

   // ----------------------------------------------------------------
   // Function codes
   // ----------------------------------------------------------------
   localparam logic [CODE_W-1:0] FC_SERVO_ON  = 8'h01;
   localparam logic [CODE_W-1:0] FC_FAULT_RST = 8'h02;
   localparam logic [CODE_W-1:0] FC_GAIN      = 8'h03;
   localparam logic [CODE_W-1:0] FC_DEV_CLR   = 8'h04;
   localparam logic [CODE_W-1:0] FC_ZERO_CLAMP_IN    = 8'h05;
   localparam logic [CODE_W-1:0] FC_HALT      = 8'h07;
   localparam logic [CODE_W-1:0] FC_STOP_DIS  = 8'h21;
   localparam logic [CODE_W-1:0] FC_NEG_LIM   = 8'h22;
   localparam logic [CODE_W-1:0] FC_POS_LIM   = 8'h23;
   localparam logic [CODE_W-1:0] FC_PULSE_TYP = 8'h2c;
   localparam logic [CODE_W-1:0] FC_AUTO_SEQ  = 8'h42;
   localparam logic [CODE_W-1:0] FC_INHIBIT   = 8'h45;
   localparam logic [CODE_W-1:0] FC_SEQ_STOP  = 8'h46;

   // Function indices into the decoded vector
   localparam int FN_SON = 0;
   localparam int FN_FR  = 1;
   localparam int FN_GN  = 2;
   localparam int FN_DC  = 3;
   localparam int FN_ZC  = 4;
   localparam int FN_HLT = 5;
   localparam int FN_OPS = 6;
   localparam int FN_NL  = 7;
   localparam int FN_PL  = 8;
   localparam int FN_PT  = 9;
   localparam int FN_AR  = 10;
   localparam int FN_IH  = 11;
   localparam int FN_SP  = 12;

   // Code table, entry k belongs to index k
   localparam logic [NUM_FUNCS-1:0][CODE_W-1:0] FUNC_CODES = {
      FC_SEQ_STOP, FC_INHIBIT, FC_AUTO_SEQ, FC_PULSE_TYP, FC_POS_LIM,
      FC_NEG_LIM, FC_STOP_DIS, FC_HALT, FC_ZERO_CLAMP_IN, FC_DEV_CLR, FC_GAIN,
      FC_FAULT_RST, FC_SERVO_ON};

   // Functions still honoured under exclusive access
   localparam logic [NUM_FUNCS-1:0] EXCL_KEEP = 13'h01a3;

   // ----------------------------------------------------------------
   // Operating modes and control values
   // ----------------------------------------------------------------
   localparam logic [MODE_W-1:0] MODE_PT  = 4'h0;
   localparam logic [MODE_W-1:0] MODE_PS  = 4'h1;
   localparam logic [MODE_W-1:0] MODE_V   = 4'h2;
   localparam logic [MODE_W-1:0] MODE_T   = 4'h3;
   localparam logic [MODE_W-1:0] MODE_VZ  = 4'h4;
   localparam logic [MODE_W-1:0] MODE_TZ  = 4'h5;
   localparam logic [MODE_W-1:0] MODE_PTV = 4'h6;
   localparam logic [MODE_W-1:0] MODE_PTT = 4'h7;
   localparam logic [MODE_W-1:0] MODE_PSV = 4'h8;
   localparam logic [MODE_W-1:0] MODE_PST = 4'h9;
   localparam logic [MODE_W-1:0] MODE_VT  = 4'ha;

   localparam logic [DATA_W-1:0] LINEAR_CTRL  = 16'h4001;
   localparam int                ZC_BEH_BIT   = 10;
   localparam int                DC_EDGE_BIT  = 0;
   localparam int                EXCL_BIT     = 0;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_MAP0   = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_GAIN   = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_DCLR   = 5'h09;
   localparam logic [ADDR_W-1:0] OFS_CMODE  = 5'h0a;
   localparam logic [ADDR_W-1:0] OFS_ZCSPD  = 5'h0b;
   localparam logic [ADDR_W-1:0] OFS_EXTF   = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_OPMODE = 5'h0d;
   localparam logic [ADDR_W-1:0] OFS_ACCESS = 5'h0e;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_FUNCS  = 5'h11;

   // Reset values
   localparam logic [CODE_W-1:0] RST_MAP    = 8'h00;
   localparam logic [DATA_W-1:0] RST_GAIN   = 16'h0000;
   localparam logic [DATA_W-1:0] RST_DCLR   = 16'h0000;
   localparam logic [DATA_W-1:0] RST_CMODE  = 16'h4001;
   localparam logic [DATA_W-1:0] RST_ZCSPD  = 16'h000a;
   localparam logic [DATA_W-1:0] RST_EXTF   = 16'h0000;
   localparam logic [MODE_W-1:0] RST_OPMODE = 4'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_DISABLED = 3'b001,              // Power stage off
      ST_ENABLED  = 3'b010,              // Operation enabled
      ST_STOPPING = 3'b100               // Decelerating before off
   } drive_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;           // Register index
      logic [DATA_W-1:0] wdata;          // Write data
      logic              wr;             // Write strobe
      logic              rd;             // Read strobe
   } bus_req_t;

   typedef struct packed {
      logic power_enable;                // Power stage on
      logic operation_enabled;           // Operation enabled state
      logic decel_request;               // Ramp down before off
      logic fault_reset;                 // Fault reset pulse
      logic error_reset;                 // Error message reset pulse
      logic gain_raise;                  // Raised gain in force
      logic deviation_clear;             // Clear position deviation
      logic zero_clamp_stop;             // Hold motor at standstill
      logic zero_clamp_ref_zero;         // Force speed reference zero
      logic pulse_type_high;             // High-speed pulse inputs
      logic pulse_inputs_enable;         // Pulse inputs accepted
      logic seq_stop;                    // Stop in sequence mode
      logic auto_run;                    // Automatic sequence runs
      logic auto_first_set;              // Restart at first set pulse
      logic halt;                        // Halt function
      logic neg_limit;                   // Negative limit switch
      logic pos_limit;                   // Positive limit switch
   } drive_out_t;

endpackage : dimap_pkg

// [rtl/digital_input_function_mapper.sv]
// Maps eight digital input pins onto coded drive functions.
// Assumes error, standstill and speed come from sys_clk logic;
// pins are asynchronous and are synchronised here.
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps

module digital_input_function_mapper
#(
   parameter int NIN = dimap_pkg::NUM_INPUTS   // Input count
)
(
   input  wire logic                        sys_clk,
   input  wire logic                        reset,
   input  wire logic                        ce,
   input  wire logic [NIN-1:0]              digital_input_pins,
   input  wire dimap_pkg::bus_req_t         bus_req,
   output logic      [dimap_pkg::DATA_W-1:0] rd_data,
   input  wire logic                        error_present,
   input  wire logic                        motor_standstill,
   input  wire logic [dimap_pkg::DATA_W-1:0] motor_speed,
   output dimap_pkg::drive_out_t            drive_out
);
   import dimap_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [NIN-1:0][CODE_W-1:0] map;      // Function code per input
      logic [DATA_W-1:0]          gain;     // Gain switching setting
      logic [DATA_W-1:0]          dclr;     // Deviation clear setting
      logic [DATA_W-1:0]          cmode;    // Control mode setting
      logic [DATA_W-1:0]          zcspd;    // Zero clamp threshold
      logic [DATA_W-1:0]          extf;     // Extended functions
      logic [MODE_W-1:0]          opmode;   // Operating mode
      logic                       excl;     // Exclusive access active
      logic [NUM_FUNCS-1:0]       prev;     // Last effective functions
      drive_state_t               dstate;   // Power stage sequence
      drive_out_t                 out;      // Registered outputs
      logic [DATA_W-1:0]          rdata;    // Read return
   } state_t;

   state_t s_reg;                          // Current state
   state_t s_next;                         // Next state

   logic [NIN-1:0]       din;              // Synchronised inputs
   logic [NUM_FUNCS-1:0] func_raw;         // Decoded functions
   logic [NUM_FUNCS-1:0] eff;              // After access gating
   logic [NUM_FUNCS-1:0] rise;             // Rising edges
   logic [NUM_FUNCS-1:0] fall;             // Falling edges
   logic                 torque_mode;      // Mode contains torque
   logic                 vel_mode;         // Plain velocity mode
   logic                 pt_mode;          // Pulse train in use
   logic                 ps_mode;          // Plain position sequence mode
   logic                 want_on;          // Servo-on may enable
   logic                 want_off;         // Disable request

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   input_sync #(.WIDTH(NIN)) u_sync
   (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .ce       (ce),
      .pin_in   (digital_input_pins),
      .sync_out (din)
   );

   // ----------------------------------------------------------------
   // Function decode
   // ----------------------------------------------------------------
   // Each function is the OR of all inputs carrying its code
   genvar k, i;
   generate
      for (k = 0; k < NUM_FUNCS; k++)
      begin : g_func
         logic [NIN-1:0] hit;            // Inputs carrying this code
         for (i = 0; i < NIN; i++)
         begin : g_in
            assign hit[i] = din[i] && (s_reg.map[i] == FUNC_CODES[k]);
         end
         assign func_raw[k] = |hit;
      end
   endgenerate

   // ----------------------------------------------------------------
   // Mode classes and edges
   // ----------------------------------------------------------------
   // Exclusive access drops all but servo-on, fault reset, halt and both limit switches
   always_comb
   begin
      eff  = s_reg.excl ? (func_raw & EXCL_KEEP) : func_raw;
      rise = eff & ~s_reg.prev;
      fall = ~eff & s_reg.prev;
      torque_mode = (s_reg.opmode == MODE_T)   || (s_reg.opmode == MODE_TZ)  ||
                    (s_reg.opmode == MODE_PTT) || (s_reg.opmode == MODE_PST) ||
                    (s_reg.opmode == MODE_VT);
      vel_mode = (s_reg.opmode == MODE_V);
      pt_mode  = (s_reg.opmode == MODE_PT)  || (s_reg.opmode == MODE_PTV) ||
                 (s_reg.opmode == MODE_PTT);
      ps_mode  = (s_reg.opmode == MODE_PS);
      // Enable only with no error and not under exclusive access
      want_on  = eff[FN_SON] && !error_present && !eff[FN_OPS] &&
                 !s_reg.excl;
      // Off on falling servo-on, stop input or error
      want_off = !eff[FN_SON] || fall[FN_SON] || eff[FN_OPS] ||
                 error_present;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_next      = s_reg;
      s_next.prev = eff;

      // Register writes
      if (bus_req.wr)
      begin
         if (bus_req.addr < OFS_GAIN)
         begin
            // Map entry per input
            s_next.map[bus_req.addr[2:0]] = bus_req.wdata[CODE_W-1:0];
         end
         else
         begin
            unique case (bus_req.addr)
               OFS_GAIN:   s_next.gain   = bus_req.wdata;
               OFS_DCLR:   s_next.dclr   = bus_req.wdata;
               OFS_CMODE:  s_next.cmode  = bus_req.wdata;
               OFS_ZCSPD:  s_next.zcspd  = bus_req.wdata;
               OFS_EXTF:   s_next.extf   = bus_req.wdata;
               OFS_OPMODE: s_next.opmode = bus_req.wdata[MODE_W-1:0];
               OFS_ACCESS: s_next.excl   = bus_req.wdata[EXCL_BIT];
               default:    ;            // Unmapped writes ignored
            endcase
         end
      end

      // Register reads, unmapped return zero
      s_next.rdata = '0;
      if (bus_req.rd)
      begin
         if (bus_req.addr < OFS_GAIN)
         begin
            s_next.rdata[CODE_W-1:0] = s_reg.map[bus_req.addr[2:0]];
         end
         else
         begin
            unique case (bus_req.addr)
               OFS_GAIN:   s_next.rdata = s_reg.gain;
               OFS_DCLR:   s_next.rdata = s_reg.dclr;
               OFS_CMODE:  s_next.rdata = s_reg.cmode;
               OFS_ZCSPD:  s_next.rdata = s_reg.zcspd;
               OFS_EXTF:   s_next.rdata = s_reg.extf;
               OFS_OPMODE: s_next.rdata[MODE_W-1:0] = s_reg.opmode;
               OFS_ACCESS: s_next.rdata[EXCL_BIT] = s_reg.excl;
               OFS_STATUS: s_next.rdata = {4'h0, error_present,
                                           s_reg.dstate, din};
               OFS_FUNCS:  s_next.rdata = {3'h0, s_reg.prev};
               default:    s_next.rdata = '0;
            endcase
         end
      end

      // Power stage sequence
      unique case (s_reg.dstate)
         ST_DISABLED:
         begin
            if (want_on)
               s_next.dstate = ST_ENABLED;
         end
         ST_ENABLED:
         begin
            // Torque modes coast, others ramp first
            if (want_off)
               s_next.dstate = torque_mode ? ST_DISABLED : ST_STOPPING;
         end
         ST_STOPPING:
         begin
            if (motor_standstill)
               s_next.dstate = ST_DISABLED;
         end
         default:
            s_next.dstate = ST_DISABLED;
      endcase

      // Outputs
      s_next.out.power_enable      = (s_next.dstate != ST_DISABLED);
      s_next.out.operation_enabled = (s_next.dstate == ST_ENABLED);
      s_next.out.decel_request     = (s_next.dstate == ST_STOPPING);
      // Fault reset on its rising edge
      s_next.out.fault_reset = rise[FN_FR];
      // Error message cleared by either rising edge
      s_next.out.error_reset = rise[FN_FR] || rise[FN_SON];
      // Gain raise only when switching is configured
      s_next.out.gain_raise  = eff[FN_GN] && (s_reg.gain != '0);
      // Level or edge clear, linear control only
      s_next.out.deviation_clear = (s_reg.cmode == LINEAR_CTRL) &&
         (s_reg.dclr[DC_EDGE_BIT] ? rise[FN_DC] : eff[FN_DC]);
      // Zero clamp in velocity mode; stop below threshold, reference zero per extended bit
      s_next.out.zero_clamp_stop = vel_mode && eff[FN_ZC] &&
         (motor_speed < s_reg.zcspd);
      s_next.out.zero_clamp_ref_zero = vel_mode && eff[FN_ZC] &&
         s_reg.extf[ZC_BEH_BIT];
      // Pulse type applies to pulse train modes
      s_next.out.pulse_type_high = pt_mode && eff[FN_PT];
      // Pulse inputs off under exclusive access or inhibit
      s_next.out.pulse_inputs_enable = !s_reg.excl && !eff[FN_IH];
      // Stop only honoured in sequence mode
      s_next.out.seq_stop = ps_mode && eff[FN_SP];
      // Automatic sequence, restart from first set on rise
      s_next.out.auto_run       = eff[FN_AR];
      s_next.out.auto_first_set = rise[FN_AR];
      // Safety functions stay live under exclusive access
      s_next.out.halt      = eff[FN_HLT];
      s_next.out.neg_limit = eff[FN_NL];
      s_next.out.pos_limit = eff[FN_PL];
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         s_reg.map    <= {NIN{RST_MAP}};
         s_reg.gain   <= RST_GAIN;
         s_reg.dclr   <= RST_DCLR;
         s_reg.cmode  <= RST_CMODE;
         s_reg.zcspd  <= RST_ZCSPD;
         s_reg.extf   <= RST_EXTF;
         s_reg.opmode <= RST_OPMODE;
         s_reg.excl   <= 1'b0;
         s_reg.prev   <= '0;
         s_reg.dstate <= ST_DISABLED;
         s_reg.out    <= '0;
         s_reg.rdata  <= '0;
      end
      else if (ce)
      begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------------------------------
   // Ports from state
   // ----------------------------------------------------------------
   assign rd_data   = s_reg.rdata;
   assign drive_out = s_reg.out;

endmodule : digital_input_function_mapper

// [rtl/input_sync.sv]
// Two-stage synchroniser for the digital input pins.
// Assumes pins are asynchronous to sys_clk; ce freezes both stages.
`timescale 1ns/1ps

module input_sync
#(
   parameter int WIDTH = 8               // Number of pins
)
(
   input  wire logic             sys_clk,
   input  wire logic             reset,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] pin_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ----------------------------------------------------------------
   // Per-pin flop pair
   // ----------------------------------------------------------------
   genvar b;
   generate
      for (b = 0; b < WIDTH; b++)
      begin : g_bit
         logic meta_reg;                 // First stage, read by second only

         // Capture then resample
         always_ff @(posedge sys_clk or posedge reset)
         begin
            if (reset)
            begin
               meta_reg    <= 1'b0;
               sync_out[b] <= 1'b0;
            end
            else if (ce)
            begin
               meta_reg    <= pin_in[b];
               sync_out[b] <= meta_reg;
            end
         end
      end
   endgenerate

endmodule : input_sync

// [sim/dimap_checker.sv]
// Port-level checks of the digital input function mapper.
// Assumes one clock domain and the async active-high reset.
`timescale 1ns/1ps

module dimap_checker
#(
   parameter int NIN = 8
)
(
   input wire logic                         sys_clk,
   input wire logic                         reset,
   input wire logic                         ce,
   input wire logic [NIN-1:0]               digital_input_pins,
   input wire dimap_pkg::bus_req_t          bus_req,
   input wire logic [dimap_pkg::DATA_W-1:0] rd_data,
   input wire logic                         error_present,
   input wire logic                         motor_standstill,
   input wire logic [dimap_pkg::DATA_W-1:0] motor_speed,
   input wire dimap_pkg::drive_out_t        drive_out
);
   import dimap_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   a_read_idle: assert property (!$past(bus_req.rd) |-> rd_data == '0)
      else $error("read data outside read cycle");
   a_err_blocks_on: assert property ($rose(drive_out.power_enable) |-> !$past(error_present))
      else $error("power stage enabled with error");
   a_on_pair: assert property ($rose(drive_out.power_enable) |-> drive_out.operation_enabled)
      else $error("enable without operation state");
   a_oper_power: assert property (drive_out.operation_enabled |-> drive_out.power_enable)
      else $error("operation state without power");
   a_decel_power: assert property (drive_out.decel_request |-> drive_out.power_enable)
      else $error("ramp request with power off");
   a_fault_pulse: assert property (drive_out.fault_reset |=> !drive_out.fault_reset)
      else $error("fault reset longer than one cycle");
   a_err_rst_pulse: assert property (drive_out.error_reset |=> !drive_out.error_reset)
      else $error("error reset longer than one cycle");
   a_fault_clears: assert property (drive_out.fault_reset |-> drive_out.error_reset)
      else $error("fault reset without error reset");
   a_auto_first: assert property ($rose(drive_out.auto_run) |-> drive_out.auto_first_set)
      else $error("sequence start without first set");
endmodule : dimap_checker

bind digital_input_function_mapper dimap_checker #(.NIN(NIN)) chk (.sys_clk(sys_clk),
   .reset(reset), .ce(ce), .digital_input_pins(digital_input_pins), .bus_req(bus_req),
   .rd_data(rd_data), .error_present(error_present), .motor_standstill(motor_standstill),
   .motor_speed(motor_speed), .drive_out(drive_out));

// [sim/input_driver_model.sv]
// Model of the outside controller driving the eight input lines.
// Assumes the bench asks for line levels on sys_clk; lines move one edge later.
`timescale 1ns/1ps

module input_driver_model
(
   input  wire logic       sys_clk,
   input  wire logic [7:0] level_req,
   output logic      [7:0] pins
);
   // Lines idle low until the controller asks otherwise
   initial pins = 8'h00;

   // Outputs switch just after an edge, never mid-cycle
   always @(posedge sys_clk)
      pins <= level_req;
endmodule : input_driver_model

// [sim/test_digital_input_function_mapper.sv]
// Self-checking bench for the digital input function mapper.
// Assumes ce tied high; the controller model drives the input lines.
`timescale 1ns/1ps

module test_digital_input_function_mapper;
   import dimap_pkg::*;
   logic              sys_clk = 1'b0;
   logic              reset   = 1'b1;
   logic              err     = 1'b0;   // Error present
   logic              still   = 1'b0;   // Motor standstill
   logic [7:0]        lvl     = 8'h00;  // Requested line levels
   wire  [7:0]        pins;
   logic [DATA_W-1:0] spd     = 16'h0005;
   logic [DATA_W-1:0] rdd;
   bus_req_t          req     = '0;
   drive_out_t        dout;
   int                mismatches  = 0;
   int                check_count = 0;

   always #20 sys_clk = ~sys_clk;

   digital_input_function_mapper dut (.sys_clk(sys_clk), .reset(reset), .ce(1'b1),
      .digital_input_pins(pins), .bus_req(req), .rd_data(rdd), .error_present(err),
      .motor_standstill(still), .motor_speed(spd), .drive_out(dout));
   input_driver_model pdrv (.sys_clk(sys_clk), .level_req(lvl), .pins(pins));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task cmp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : cmp

   task wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      req <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task rdc(input logic [4:0] a, input logic [15:0] e);
      @(posedge sys_clk);
      req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 cmp(rdd, e);
   endtask : rdc

   // Line change, then the three edges of sync and decode
   task pin(input int i, input logic v);
      @(posedge sys_clk);
      lvl[i] <= v;
      repeat (4) @(posedge sys_clk);
      #1;
   endtask : pin

   task wait_n(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_n

   task give_verdict;
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : give_verdict

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_regs;
      rdc(OFS_CMODE, RST_CMODE);
      rdc(OFS_ZCSPD, RST_ZCSPD);
      rdc(5'h1f, 16'h0000);
      for (int i = 0; i < 8; i++)
      begin
         wr(OFS_MAP0 + 5'(i), 16'h0050 + 16'(i));
         rdc(OFS_MAP0 + 5'(i), 16'h0050 + 16'(i));
         wr(OFS_MAP0 + 5'(i), 16'h0000);
      end
   endtask : t_regs

   task t_servo;
      wr(OFS_MAP0 + 5'd3, 16'(FC_SERVO_ON));
      pin(3, 1'b1);
      cmp(16'(dout.power_enable), 16'h0001);
      cmp(16'(dout.error_reset), 16'h0001);
      rdc(OFS_FUNCS, 16'h0001);
      @(posedge sys_clk);
      err <= 1'b1;
      wait_n(2);
      cmp(16'(dout.decel_request), 16'h0001);
      @(posedge sys_clk);
      still <= 1'b1;
      wait_n(3);
      cmp(16'(dout.power_enable), 16'h0000);
      pin(3, 1'b0);
      pin(3, 1'b1);
      cmp(16'(dout.power_enable), 16'h0000);
      @(posedge sys_clk);
      err <= 1'b0;
      wait_n(3);
      cmp(16'(dout.power_enable), 16'h0001);
      pin(3, 1'b0);
      wait_n(3);
   endtask : t_servo

   // Torque modes drop power with no ramp request
   task t_torque;
      @(posedge sys_clk);
      still <= 1'b0;
      wr(OFS_OPMODE, 16'(MODE_T));
      pin(3, 1'b1);
      cmp(16'(dout.power_enable), 16'h0001);
      pin(3, 1'b0);
      cmp(16'(dout.decel_request), 16'h0000);
      wait_n(2);
      cmp(16'(dout.power_enable), 16'h0000);
      wr(OFS_MAP0 + 5'd5, 16'(FC_STOP_DIS));
      pin(3, 1'b1);
      pin(5, 1'b1);
      cmp(16'(dout.power_enable), 16'h0000);
      pin(3, 1'b0);
      wr(OFS_OPMODE, 16'(MODE_PT));
   endtask : t_torque

   task t_clears;
      wr(OFS_MAP0 + 5'd1, 16'(FC_FAULT_RST));
      pin(1, 1'b1);
      cmp(16'(dout.fault_reset), 16'h0001);
      cmp(16'(dout.error_reset), 16'h0001);
      wait_n(1);
      cmp(16'(dout.fault_reset), 16'h0000);
      wr(OFS_MAP0 + 5'd2, 16'(FC_DEV_CLR));
      pin(2, 1'b1);
      cmp(16'(dout.deviation_clear), 16'h0001);
      pin(2, 1'b0);
      wr(OFS_CMODE, 16'h4000);
      pin(2, 1'b1);
      cmp(16'(dout.deviation_clear), 16'h0000);
      pin(2, 1'b0);
      wr(OFS_CMODE, LINEAR_CTRL);
      wr(OFS_DCLR, 16'h0001);
      pin(2, 1'b1);
      cmp(16'(dout.deviation_clear), 16'h0001);
      wait_n(1);
      cmp(16'(dout.deviation_clear), 16'h0000);
   endtask : t_clears

   task t_modes;
      wr(OFS_MAP0 + 5'd4, 16'(FC_PULSE_TYP));
      wr(OFS_MAP0 + 5'd5, 16'(FC_SEQ_STOP));
      wr(OFS_MAP0 + 5'd6, 16'(FC_AUTO_SEQ));
      pin(4, 1'b1);
      cmp(16'(dout.pulse_type_high), 16'h0001);
      pin(5, 1'b1);
      cmp(16'(dout.seq_stop), 16'h0000);
      pin(6, 1'b1);
      cmp(16'(dout.auto_first_set), 16'h0001);
      cmp(16'(dout.auto_run), 16'h0001);
      wr(OFS_OPMODE, 16'(MODE_PS));
      wait_n(2);
      cmp(16'(dout.seq_stop), 16'h0001);
      wr(OFS_OPMODE, 16'(MODE_V));
      wr(OFS_MAP0 + 5'd7, 16'(FC_ZERO_CLAMP_IN));
      pin(7, 1'b1);
      cmp(16'(dout.zero_clamp_stop), 16'h0001);
      cmp(16'(dout.zero_clamp_ref_zero), 16'h0000);
      wr(OFS_EXTF, 16'h0400);
      wait_n(2);
      cmp(16'(dout.zero_clamp_ref_zero), 16'h0001);
      @(posedge sys_clk);
      spd <= 16'h0014;
      wait_n(2);
      cmp(16'(dout.zero_clamp_stop), 16'h0000);
   endtask : t_modes

   // Exclusive access drops pulse inputs, keeps halt
   task t_excl;
      wr(OFS_GAIN, 16'h0001);
      wr(OFS_MAP0 + 5'd2, 16'(FC_GAIN));
      wr(OFS_MAP0 + 5'd1, 16'(FC_NEG_LIM));
      wr(OFS_MAP0 + 5'd7, 16'(FC_POS_LIM));
      wait_n(2);
      cmp(16'(dout.gain_raise), 16'h0001);
      cmp(16'(dout.pulse_inputs_enable), 16'h0001);
      wr(OFS_MAP0, 16'(FC_HALT));
      wr(OFS_ACCESS, 16'h0001);
      pin(0, 1'b1);
      cmp(16'(dout.pulse_inputs_enable), 16'h0000);
      cmp(16'(dout.halt), 16'h0001);
      cmp(16'(dout.neg_limit), 16'h0001);
      cmp(16'(dout.pos_limit), 16'h0001);
      cmp(16'(dout.auto_run), 16'h0000);
   endtask : t_excl

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge sys_clk);
      reset <= 1'b0;
      t_regs;
      t_servo;
      t_torque;
      t_clears;
      t_modes;
      t_excl;
      give_verdict;
   end

   initial
   begin
      #200000;
      mismatches++;
      give_verdict;
   end
endmodule : test_digital_input_function_mapper
